//--- rtl/boot_cfg_pkg.sv
package boot_cfg_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [31:0] REGION_BASE = 32'h4000_0000;
  localparam logic [31:0] REGION_END = 32'h4000_0083;
  localparam logic [31:0] OFS_BOOT_PIN_CAPTURE_LOW = 32'h4000_0000;
  localparam logic [31:0] OFS_BRIDGE_RESET_CONTROL = 32'h4000_0024;
  localparam logic [31:0] OFS_BOOT_STATUS = 32'h4000_0040;
  localparam logic [31:0] BOOT_FETCH_ADDR = 32'h0000_0000;
  localparam int BRIDGE_RESET_BIT = 0;
  localparam logic BRIDGE_RESET_INIT = 1'b1;
  localparam int CAP_W = 8;
  localparam logic [7:0] CAP_INIT = 8'h00;
  localparam int CAP_SER0_SLAVE_OUT = 7;
  localparam int CAP_SER0_SLAVE_IN = 6;
  localparam int CAP_SER0_CLOCK = 5;
  localparam int CAP_SER0_CHIP_SELECT = 4;
  localparam int CAP_SER0_ENABLE = 3;
  localparam int CAP_SER1_SLAVE_OUT = 2;
  localparam int CAP_SER1_SLAVE_IN = 1;
  localparam int CAP_SER1_CLOCK = 0;
  localparam int STAT_HOST_BOOT = 0;
  localparam int STAT_MODE_LSB = 1;
  localparam int HOST_CFG_W = 3;
  localparam logic [2:0] HOST_CFG_INIT = 3'h0;
  typedef enum logic [2:0] {
    BOOT_HOST = 3'b100,
    BOOT_PAR_FLASH = 3'b010,
    BOOT_SER_MASTER = 3'b001,
    BOOT_SER_SLAVE = 3'b011,
    BOOT_TWI_MASTER = 3'b101,
    BOOT_TWI_SLAVE = 3'b111,
    BOOT_UNKNOWN = 3'b000
  } boot_mode_t;
endpackage : boot_cfg_pkg

//--- rtl/boot_pin_capture_config.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
// Summary of operation
// - Bridge control bit 0 holds memory port bridge in reset; resets to 1.
// - Reserved bits read undefined (zero here); software writes zeros.
// - Configuration region 0x40000000 to 0x40000083 takes full-word accesses only.
// - Byte-wide accesses to these registers are rejected with an error.
// - Processor always starts fetching internal ROM at address zero.
// - Capture register latches eight boot pins on external reset rising edge.
// - Only external reset recaptures; emulator or watchdog resets leave captures.
// - Bits 7..3 serial0 out,in,clock,select,enable; bits 2..0 serial1 out,in,clock.
// - Host select low copies serial0 out,in,clock into host port configuration.
// - Bridge carries peripheral clock masters to core clock ROM and RAM.
module boot_pin_capture_config (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ext_reset_n,
  input wire logic i_emu_reset,
  input wire logic i_watchdog_reset,
  input wire logic i_serial0_slave_out,
  input wire logic i_serial0_slave_in,
  input wire logic i_serial0_clock,
  input wire logic i_serial0_chip_select,
  input wire logic i_serial0_enable,
  input wire logic i_serial1_slave_out,
  input wire logic i_serial1_slave_in,
  input wire logic i_serial1_clock,
  input wire logic i_host_port_chip_select,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [boot_cfg_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [boot_cfg_pkg::DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [boot_cfg_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_mem_port_bridge_reset,
  output logic [boot_cfg_pkg::ADDR_W-1:0] o_boot_fetch_addr,
  output logic o_host_byte_addressing,
  output logic o_host_full_width,
  output logic o_host_nonmultiplexed,
  output logic o_host_config_valid
);
  import boot_cfg_pkg::*;

  logic [CAP_W-1:0] pin_meta;
  logic [CAP_W-1:0] pin_sync;
  logic host_cs_meta;
  logic host_cs_sync;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [CAP_W-1:0] boot_pin_capture_low;
  logic captured_host_boot;
  logic bridge_reset;
  logic [HOST_CFG_W-1:0] host_cfg;
  logic host_cfg_valid;
  logic access;
  logic word_ok;
  logic hit_cap;
  logic hit_bridge;
  logic hit_status;
  logic bad;
  logic [DATA_W-1:0] next_prdata;
  boot_mode_t mode;

  function automatic boot_mode_t decode_mode(input logic host_cs, input logic [2:0] ser);
    if (!host_cs) begin
      decode_mode = BOOT_HOST;
    end else begin
      unique case (ser)
        3'b010: decode_mode = BOOT_PAR_FLASH;
        3'b001: decode_mode = BOOT_SER_MASTER;
        3'b011: decode_mode = BOOT_SER_SLAVE;
        3'b101: decode_mode = BOOT_TWI_MASTER;
        3'b111: decode_mode = BOOT_TWI_SLAVE;
        default: decode_mode = BOOT_UNKNOWN;
      endcase
    end
  endfunction : decode_mode

  // Pins are asynchronous straps, so two flops before anything reads them.
  always_ff @(posedge i_clk) begin
    pin_meta <= {i_serial0_slave_out, i_serial0_slave_in, i_serial0_clock, i_serial0_chip_select,
                 i_serial0_enable, i_serial1_slave_out, i_serial1_slave_in, i_serial1_clock};
    pin_sync <= pin_meta;
    host_cs_meta <= i_host_port_chip_select;
    host_cs_sync <= host_cs_meta;
    ext_meta <= i_ext_reset_n;
    ext_sync <= ext_meta;
  end

  // The release edge is detected on the synchronised pin, so the capture lands two to three cycles late.
  // The edge flop is not cleared by the system reset, since that reset may be the emulator or watchdog.
  always_ff @(posedge i_clk) begin
    ext_prev <= ext_sync;
  end

  // Capture ignores i_reset_n entirely so emulator and watchdog resets keep the values.
  always_ff @(posedge i_clk) begin
    if (ext_sync && !ext_prev) begin
      boot_pin_capture_low[CAP_SER0_SLAVE_OUT] <= pin_sync[7];
      boot_pin_capture_low[CAP_SER0_SLAVE_IN] <= pin_sync[6];
      boot_pin_capture_low[CAP_SER0_CLOCK] <= pin_sync[5];
      boot_pin_capture_low[CAP_SER0_CHIP_SELECT] <= pin_sync[4];
      boot_pin_capture_low[CAP_SER0_ENABLE] <= pin_sync[3];
      boot_pin_capture_low[CAP_SER1_SLAVE_OUT] <= pin_sync[2];
      boot_pin_capture_low[CAP_SER1_SLAVE_IN] <= pin_sync[1];
      boot_pin_capture_low[CAP_SER1_CLOCK] <= pin_sync[0];
      captured_host_boot <= !host_cs_sync;
    end else if (!ext_sync) begin
      boot_pin_capture_low <= CAP_INIT;
      captured_host_boot <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!ext_sync) begin
      host_cfg <= HOST_CFG_INIT;
      host_cfg_valid <= 1'b0;
    end else if (ext_sync && !ext_prev && !host_cs_sync) begin
      host_cfg <= pin_sync[7:5];
      host_cfg_valid <= 1'b1;
    end
  end

  assign mode = decode_mode(!captured_host_boot,
    {boot_pin_capture_low[CAP_SER0_SLAVE_OUT], boot_pin_capture_low[CAP_SER0_SLAVE_IN],
     boot_pin_capture_low[CAP_SER0_CLOCK]});

  // APB decode. Full word strobes only, and only inside the region.
  assign access = i_psel && i_penable;
  assign word_ok = (i_pstrb == 4'hF) && (i_paddr[1:0] == 2'h0);
  assign hit_cap = (i_paddr == OFS_BOOT_PIN_CAPTURE_LOW);
  assign hit_bridge = (i_paddr == OFS_BRIDGE_RESET_CONTROL);
  assign hit_status = (i_paddr == OFS_BOOT_STATUS);
  assign bad = !word_ok || (i_paddr < REGION_BASE) || (i_paddr > REGION_END);
  assign o_pready = 1'b1;
  assign o_pslverr = access && bad;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bridge_reset <= BRIDGE_RESET_INIT;
    end else if (access && i_pwrite && !bad && hit_bridge) begin
      bridge_reset <= i_pwdata[BRIDGE_RESET_BIT];
    end
  end

  // Writes to the capture register fall through here and change nothing.
  always_comb begin
    next_prdata = '0;
    if (!bad && hit_cap) begin
      next_prdata[CAP_W-1:0] = boot_pin_capture_low;
    end else if (!bad && hit_bridge) begin
      next_prdata[BRIDGE_RESET_BIT] = bridge_reset;
    end else if (!bad && hit_status) begin
      next_prdata[STAT_HOST_BOOT] = captured_host_boot;
      next_prdata[STAT_MODE_LSB +: 3] = mode;
    end
  end

  // Read data is registered in the setup cycle so it is stable at the access edge.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_prdata <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= next_prdata;
    end
  end

  // The bridge (peripheral clock masters into core clock memory) is held in reset by this level.
  assign o_mem_port_bridge_reset = bridge_reset;
  assign o_boot_fetch_addr = BOOT_FETCH_ADDR;
  assign o_host_byte_addressing = host_cfg[2];
  assign o_host_full_width = host_cfg[1];
  assign o_host_nonmultiplexed = host_cfg[0];
  assign o_host_config_valid = host_cfg_valid;
endmodule : boot_pin_capture_config

//--- tb/boot_cfg_chk.sv
`timescale 1ns/100ps
module boot_cfg_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_mem_port_bridge_reset,
  input wire logic [31:0] o_boot_fetch_addr
);
  import boot_cfg_pkg::*;
  logic acc, ok, bw;
  assign acc = i_psel && i_penable;
  assign ok = i_pstrb == 4'hF && i_paddr[1:0] == 2'h0 && i_paddr >= REGION_BASE && i_paddr <= REGION_END;
  assign bw = acc && i_pwrite && ok && i_paddr == OFS_BRIDGE_RESET_CONTROL;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_bridge_init: assert property ($rose(i_reset_n) |-> o_mem_port_bridge_reset) else $error("bridge init");
  a_bridge_load: assert property (bw |=> o_mem_port_bridge_reset == $past(i_pwdata[0])) else $error("load");
  a_bridge_keep: assert property (!bw |=> $stable(o_mem_port_bridge_reset)) else $error("keep");
  a_byte_err: assert property (acc && i_pstrb != 4'hF |-> o_pslverr) else $error("byte");
  a_region_err: assert property (acc && !ok |-> o_pslverr) else $error("region");
  a_word_ok: assert property (acc && ok |-> !o_pslverr) else $error("word");
  a_ready_next: assert property (i_psel && !i_penable |=> o_pready) else $error("ready");
  a_fetch_zero: assert property (o_boot_fetch_addr == BOOT_FETCH_ADDR) else $error("fetch");
  c_clear: cover property (bw && !i_pwdata[0]);
  c_byte: cover property (acc && i_pstrb != 4'hF);
  c_read: cover property (acc && ok && !i_pwrite);
endmodule : boot_cfg_chk

//--- tb/strap_board.sv
`timescale 1ns/100ps
module strap_board (
  input wire logic [8:0] i_straps,
  output logic o_host_cs,
  output logic [7:0] o_pins
);
  // Straps are plain levels held by the board, so they stay steady across the reset release.
  assign o_host_cs = i_straps[8];
  assign o_pins = i_straps[7:0];
endmodule : strap_board

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import boot_cfg_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, ext_n = 1'b0, emu = 1'b0, wdg = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, fetch, r;
  logic [3:0] pstrb = 4'hF;
  logic [8:0] straps = 9'h1FF;
  logic [8:0] pats [6] = '{9'h0B3, 9'h14C, 9'h12D, 9'h16A, 9'h1B6, 9'h1F1};
  logic [7:0] pins;
  logic hcs, pready, perr, bridge, hb, hf, hn, hv, e;
  int fails = 0, checks_done = 0, cyc = 0;
  strap_board strap_board_inst (.i_straps(straps), .o_host_cs(hcs), .o_pins(pins));
  boot_pin_capture_config boot_pin_capture_config_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ext_reset_n(ext_n),
    .i_emu_reset(emu), .i_watchdog_reset(wdg), .i_serial0_slave_out(pins[7]), .i_serial0_slave_in(pins[6]),
    .i_serial0_clock(pins[5]), .i_serial0_chip_select(pins[4]), .i_serial0_enable(pins[3]),
    .i_serial1_slave_out(pins[2]), .i_serial1_slave_in(pins[1]), .i_serial1_clock(pins[0]),
    .i_host_port_chip_select(hcs), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
    .o_mem_port_bridge_reset(bridge), .o_boot_fetch_addr(fetch), .o_host_byte_addressing(hb),
    .o_host_full_width(hf), .o_host_nonmultiplexed(hn), .o_host_config_valid(hv));
  initial forever #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  task end_sim;
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checks_done++;
    if (s !== x) begin
      $display("BAD %s expected %h seen %h", n, x, s);
      fails++;
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task t_bridge;
    apb(0, OFS_BRIDGE_RESET_CONTROL, 32'h0, 4'hF);
    chk("brg rst", 32'h1, r);
    apb(1, OFS_BRIDGE_RESET_CONTROL, 32'h0, 4'hF);
    apb(1, OFS_BRIDGE_RESET_CONTROL, 32'h1, 4'h1);
    chk("byte err", 32'h1, {31'h0, e});
    apb(0, OFS_BRIDGE_RESET_CONTROL, 32'h0, 4'hF);
    chk("brg clr", 32'h0, r);
    chk("brg pin", 32'h0, {31'h0, bridge});
    apb(1, OFS_BRIDGE_RESET_CONTROL, 32'h1, 4'hF);
    apb(0, OFS_BRIDGE_RESET_CONTROL, 32'h0, 4'hF);
    chk("brg set", 32'h1, r);
  endtask : t_bridge
  task t_cap(input logic [8:0] p);
    straps <= p;
    ext_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    ext_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    apb(0, OFS_BOOT_PIN_CAPTURE_LOW, 32'h0, 4'hF);
    chk("cap", {24'h0, p[7:0]}, r);
    chk("host", p[8] ? 32'h0 : {28'h0, p[7:5], 1'b1}, {28'h0, hb, hf, hn, hv});
    apb(0, OFS_BOOT_STATUS, 32'h0, 4'hF);
    chk("status", p[8] ? {28'h0, p[7:5], 1'b0} : 32'h9, r);
    apb(1, OFS_BOOT_PIN_CAPTURE_LOW, {24'h0, ~p[7:0]}, 4'hF);
    straps <= ~p;
    emu <= 1'b1;
    wdg <= 1'b1;
    repeat (4) @(posedge i_clk);
    emu <= 1'b0;
    wdg <= 1'b0;
    apb(0, OFS_BOOT_PIN_CAPTURE_LOW, 32'h0, 4'hF);
    chk("keep", {24'h0, p[7:0]}, r);
  endtask : t_cap
  task t_err;
    apb(1, 32'h4000_0084, 32'h0, 4'hF);
    chk("past end", 32'h1, {31'h0, e});
    apb(0, 32'h4000_0026, 32'h0, 4'hF);
    chk("unaligned", 32'h1, {31'h0, e});
    apb(0, 32'h4000_0010, 32'h0, 4'hF);
    chk("hole", 32'h0, {31'h0, e});
    chk("fetch", 32'h0, fetch);
  endtask : t_err
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_bridge();
    for (int i = 0; i < 6; i++) t_cap(pats[i]);
    t_err();
    end_sim();
  end
endmodule : tb_top
bind boot_pin_capture_config boot_cfg_chk boot_cfg_chk_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mem_port_bridge_reset(o_mem_port_bridge_reset),
  .o_boot_fetch_addr(o_boot_fetch_addr));
